// >>> rtl/fdt_consts.svh
// Purpose: Constants for the discovery-table read path
// Assumes: Included by its bare name from the table ROM and read-path modules
// Notes:   Timing counts are in serial clock edges, not mclk cycles
`ifndef FDT_CONSTS_SVH
`define FDT_CONSTS_SVH

// Instruction code of the discovery read; arbitrary default
`define FDT_CMD_CODE      8'h5A
`define FDT_CMD_BITS      5'h08
`define FDT_ADDR_BITS     5'h18
`define FDT_DUMMY_CYC     5'h08
`define FDT_TBL_AW        11
`define FDT_TBL_LAST      11'h7FF
`define FDT_BLANK_BYTE    8'hFF
`define FDT_CNT_RST       5'h00
`define FDT_BIT_RST       3'h0
`define FDT_BIT_LAST      3'h7

`endif

// >>> rtl/fdt_pkg.sv
// Purpose: Types shared by the discovery-table read path
// Assumes: fdt_consts.svh holds the numbers
// Notes:   One-hot state codes are written out
package fdt_pkg;

   typedef enum logic [5:0] {
      FDT_ST_IDLE  = 6'b00_0001,
      FDT_ST_CMD   = 6'b00_0010,
      FDT_ST_ADDR  = 6'b00_0100,
      FDT_ST_DUMMY = 6'b00_1000,
      FDT_ST_DATA  = 6'b01_0000,
      FDT_ST_SKIP  = 6'b10_0000
   } fdt_state_e;

   // Pin samples that cross into mclk together
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } fdt_pins_s;

   // Straps reported in the first extended ID byte
   typedef struct packed {
      logic protect_alt;
      logic exec_basic;
      logic pin_reset;
   } fdt_idcfg_s;

endpackage

// >>> rtl/fdt_table_rom.sv
// Purpose: Read-only discovery table, 2048 bytes
// Assumes: Address already wrapped to table width
// Notes:   Undefined locations read as all ones
`timescale 1ns/1ps
`include "fdt_consts.svh"
module fdt_table_rom
   import fdt_pkg::*;
#(
   parameter int AW = `FDT_TBL_AW
)(
   input  wire logic [AW-1:0] addr,
   output logic      [7:0]    data
);

   always_comb begin
      case (addr)
         // Signature, revision and header count
         11'h000: data = 8'h53;
         11'h001: data = 8'h46;
         11'h002: data = 8'h44;
         11'h003: data = 8'h50;
         11'h004: data = 8'h00;
         11'h005: data = 8'h01;
         11'h006: data = 8'h00;
         // First parameter header
         11'h008: data = 8'h00;
         11'h009: data = 8'h00;
         11'h00A: data = 8'h01;
         11'h00B: data = 8'h09;
         11'h00C: data = 8'h30;
         11'h00D: data = 8'h00;
         11'h00E: data = 8'h00;
         // Erase size, granularity, no write enable needed
         11'h030: data = 8'hE5;
         11'h031: data = 8'h20;
         // Read modes, address bytes, double rate, density, fast read settings
         11'h032: data = 8'hFB;
         11'h037: data = 8'h1F;
         11'h038: data = 8'h29;
         11'h039: data = 8'hEB;
         11'h03A: data = 8'h27;
         11'h03B: data = 8'h6B;
         11'h03C: data = 8'h27;
         11'h03D: data = 8'h3B;
         11'h03E: data = 8'h27;
         11'h03F: data = 8'hBB;
         default: data = `FDT_BLANK_BYTE;
      endcase
   end

endmodule

// >>> rtl/fdt_discovery_read.sv
// Purpose: Discovery-table read path of a serial NOR flash
// Assumes: Serial mode 0/3, capture on rising, shift on falling edge
// Notes:   Pins are sampled by mclk; serial clock must be well below
//          a quarter of mclk so every edge is seen
// Functional notes
// - Select low, command on input line, 3 address bytes, 8 dummies
// - Address is always 3 bytes, whatever the array address mode
// - Output starts at received address, advancing one byte per byte
// - At the 2048-byte boundary output wraps to table address zero
// - Raising select ends the read; device stops driving three mclk later
// - Always a continuous burst; burst-wrap setting is ignored
// - Bytes 00h..03h return the four signature bytes
// - Revision, header count and reserved bytes 04h..07h
// - First parameter header fills bytes 08h..0Fh
// - Byte 30h: erase size, write granularity, reserved ones
// - Byte 30h bits 3,4 zero; byte 31h is the 4KB erase opcode
// - Byte 32h address capability; 33h..37h reserved and density
// - Byte 32h reports supported read modes and double rate
// - Bytes 38h,39h describe quad address-and-data fast read
// - Bytes 3Ah,3Bh describe quad-output fast read
// - Bytes 3Ch,3Dh describe dual-output fast read
// - Bytes 3Eh,3Fh describe dual address-and-data fast read
// - First extended ID byte: protection, execute-in-place, pin fields
// - Extended ID goes out only with the single-line ID command
`timescale 1ns/1ps
`include "fdt_consts.svh"
module fdt_discovery_read
   import fdt_pkg::*;
#(
   parameter logic [7:0] CMD_CODE = `FDT_CMD_CODE,
   parameter int         TBL_AW   = `FDT_TBL_AW
)(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       sclk_pin,
   input  wire logic       cs_n_pin,
   input  wire logic       serial_line_zero,
   input  wire logic       block_protect_scheme,
   input  wire logic       execute_in_place,
   input  wire logic       shared_pin_reset,
   output logic            data_out_ff,
   output logic            data_oe_n_ff,
   output logic            busy_ff,
   output logic [7:0]      ext_id_ff
);

   fdt_pins_s         pins_in;
   fdt_pins_s         sy1_ff;
   fdt_pins_s         sy2_ff;
   logic              sclk_d_ff;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              sel;
   fdt_state_e        state_ff;
   fdt_state_e        nxt_state;
   logic [4:0]        cnt_ff;
   logic [7:0]        cmd_sh_ff;
   logic [7:0]        cmd_word;
   logic [TBL_AW-1:0] addr_ff;
   logic [2:0]        bit_idx_ff;
   logic [7:0]        rom_byte;
   fdt_idcfg_s        idcfg;

   function automatic logic [TBL_AW-1:0] inc_addr(
      input logic [TBL_AW-1:0] a
   );
      // Natural overflow of the table width gives the wrap
      inc_addr = a + {{(TBL_AW-1){1'b0}}, 1'b1};
   endfunction

   function automatic logic last_cnt(
      input logic [4:0] c,
      input logic [4:0] len
   );
      last_cnt = (c == (len - 5'h01));
   endfunction

   assign pins_in = '{sclk: sclk_pin, cs_n: cs_n_pin,
                      din: serial_line_zero};

   // Two-stage synchroniser; only stage two is looked at
   always_ff @(posedge mclk) begin
      if (rst) begin
         sy1_ff <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
         sy2_ff <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
      end else begin
         sy1_ff <= pins_in;
         sy2_ff <= sy1_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sy2_ff.sclk;
      end
   end

   assign sclk_rise = sy2_ff.sclk & ~sclk_d_ff;
   assign sclk_fall = ~sy2_ff.sclk & sclk_d_ff;
   assign sel       = ~sy2_ff.cs_n;
   assign cmd_word  = {cmd_sh_ff[6:0], sy2_ff.din};

   always_comb begin
      nxt_state = state_ff;
      if (!sel) begin
         nxt_state = FDT_ST_IDLE;
      end else begin
         case (state_ff)
            FDT_ST_IDLE: begin
               nxt_state = FDT_ST_CMD;
            end
            FDT_ST_CMD: begin
               if (sclk_rise && last_cnt(cnt_ff, `FDT_CMD_BITS)) begin
                  // Foreign commands are left to other blocks
                  nxt_state = (cmd_word == CMD_CODE) ? FDT_ST_ADDR
                                                     : FDT_ST_SKIP;
               end
            end
            FDT_ST_ADDR: begin
               // Three bytes regardless of array address mode
               if (sclk_rise && last_cnt(cnt_ff, `FDT_ADDR_BITS)) begin
                  nxt_state = FDT_ST_DUMMY;
               end
            end
            FDT_ST_DUMMY: begin
               if (sclk_rise && last_cnt(cnt_ff, `FDT_DUMMY_CYC)) begin
                  nxt_state = FDT_ST_DATA;
               end
            end
            FDT_ST_DATA: begin
               nxt_state = FDT_ST_DATA;
            end
            FDT_ST_SKIP: begin
               nxt_state = FDT_ST_SKIP;
            end
            default: begin
               nxt_state = FDT_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_ff <= FDT_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Phase counter restarts on every phase change
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_ff <= `FDT_CNT_RST;
      end else if (!sel || nxt_state != state_ff) begin
         cnt_ff <= `FDT_CNT_RST;
      end else if (sclk_rise) begin
         cnt_ff <= cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_sh_ff <= 8'h00;
      end else if (state_ff == FDT_ST_CMD && sclk_rise) begin
         cmd_sh_ff <= cmd_word;
      end
   end

   // Only the low table bits of the 24-bit address are kept
   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_ff <= '0;
      end else if (state_ff == FDT_ST_ADDR && sclk_rise) begin
         addr_ff <= {addr_ff[TBL_AW-2:0], sy2_ff.din};
      end else if (state_ff == FDT_ST_DATA && sel && sclk_fall
                   && bit_idx_ff == `FDT_BIT_LAST) begin
         addr_ff <= inc_addr(addr_ff);
      end
   end

   fdt_table_rom #(
      .AW   (TBL_AW)
   ) u_rom (
      .addr (addr_ff),
      .data (rom_byte)
   );

   // Shift out MSB first on falling edges; release as soon as deselected
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_out_ff  <= 1'b0;
         data_oe_n_ff <= 1'b1;
         bit_idx_ff   <= `FDT_BIT_RST;
      end else if (!sel || state_ff != FDT_ST_DATA) begin
         data_out_ff  <= 1'b0;
         data_oe_n_ff <= 1'b1;
         bit_idx_ff   <= `FDT_BIT_RST;
      end else if (sclk_fall) begin
         data_out_ff  <= rom_byte[~bit_idx_ff];
         data_oe_n_ff <= 1'b0;
         bit_idx_ff   <= bit_idx_ff + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != FDT_ST_IDLE);
      end
   end

   assign idcfg = '{protect_alt: block_protect_scheme,
                    exec_basic:  execute_in_place,
                    pin_reset:   shared_pin_reset};

   // Handed to the ID command block; reserved bits read zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_id_ff <= 8'h00;
      end else begin
         ext_id_ff <= {2'b00, idcfg.protect_alt, idcfg.exec_basic,
                       idcfg.pin_reset, 1'b0, 2'b00};
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_cmd_match;
      sel && state_ff == FDT_ST_CMD && sclk_rise && cnt_ff == 5'h07
      && cmd_word == CMD_CODE;
   endsequence

   sequence s_cmd_other;
      sel && state_ff == FDT_ST_CMD && sclk_rise && cnt_ff == 5'h07
      && cmd_word != CMD_CODE;
   endsequence

   sequence s_first_fall;
      sel && state_ff == FDT_ST_DATA && sclk_fall
      && bit_idx_ff == `FDT_BIT_RST;
   endsequence

   sequence s_byte_end;
      sel && state_ff == FDT_ST_DATA && sclk_fall
      && bit_idx_ff == `FDT_BIT_LAST;
   endsequence

   a_cmd_accept: assert property (
      s_cmd_match |=> state_ff == FDT_ST_ADDR)
      else $error("matching command did not start address phase");

   a_cmd_foreign: assert property (
      s_cmd_other |=> state_ff == FDT_ST_SKIP && data_oe_n_ff)
      else $error("foreign command drove the data line");

   a_skip_quiet: assert property (
      state_ff == FDT_ST_SKIP |=> data_oe_n_ff)
      else $error("data line driven during a foreign command");

   a_addr_three: assert property (
      $rose(state_ff == FDT_ST_DUMMY) |->
         $past(cnt_ff) == 5'h17 && $past(state_ff) == FDT_ST_ADDR)
      else $error("address phase was not 24 bits");

   a_dummy_eight: assert property (
      $rose(state_ff == FDT_ST_DATA) |->
         $past(cnt_ff) == 5'h07 && $past(state_ff) == FDT_ST_DUMMY
         && data_oe_n_ff)
      else $error("data began without eight dummy clocks");

   a_first_bit: assert property (
      s_first_fall |=> !data_oe_n_ff
         && data_out_ff == $past(rom_byte[7]))
      else $error("first data bit is not table byte MSB");

   a_addr_step: assert property (
      s_byte_end |=> addr_ff - $past(addr_ff) == TBL_AW'(1))
      else $error("table address did not advance after a byte");

   a_addr_wrap: assert property (
      s_byte_end ##0 addr_ff == `FDT_TBL_LAST |=> addr_ff == '0)
      else $error("table address did not wrap to zero");

   a_addr_hold: assert property (
      state_ff == FDT_ST_DATA && !(sclk_fall && bit_idx_ff ==
         `FDT_BIT_LAST) |=> $stable(addr_ff))
      else $error("table address moved inside a byte");

   a_stop_drive: assert property (
      !sel |=> data_oe_n_ff && state_ff == FDT_ST_IDLE)
      else $error("data line still driven after deselect");

   a_drive_data: assert property (
      !data_oe_n_ff |-> $past(state_ff) == FDT_ST_DATA)
      else $error("data line driven outside data phase");

   a_signature: assert property (
      addr_ff == '0 |-> rom_byte == 8'h53)
      else $error("signature byte zero is wrong");

   a_rsvd_seven: assert property (
      addr_ff == 11'h007 |-> rom_byte == 8'hFF)
      else $error("reserved header byte is not all ones");

   a_erase_byte: assert property (
      addr_ff == 11'h030 |-> rom_byte == 8'hE5)
      else $error("erase size and granularity byte is wrong");

   a_read_modes: assert property (
      addr_ff == 11'h032 |-> rom_byte == 8'hFB)
      else $error("read mode capability byte is wrong");

   a_dual_opcode: assert property (
      addr_ff == 11'h03F |-> rom_byte == 8'hBB)
      else $error("dual address-and-data opcode is wrong");

   a_hdr_len: assert property (
      addr_ff == 11'h00B |-> rom_byte == 8'h09)
      else $error("parameter length is wrong");

   a_quad_opcode: assert property (
      addr_ff == 11'h039 |-> rom_byte == 8'hEB)
      else $error("quad address-and-data opcode is wrong");

   a_blank_fill: assert property (
      addr_ff == 11'h040 |-> rom_byte == `FDT_BLANK_BYTE)
      else $error("undefined table byte is not all ones");

   a_ext_id: assert property (
      ##1 ext_id_ff == {2'b00, $past(block_protect_scheme),
         $past(execute_in_place), $past(shared_pin_reset), 3'b000})
      else $error("extended ID byte does not follow straps");

   a_busy_track: assert property (
      busy_ff == $past(sel))
      else $error("busy flag out of step with phase");

endmodule

// >>> sim/fdt_host_model.sv
// Purpose: Host controller model that runs discovery-read frames
// Assumes: Serial clock half period is HALF mclk cycles, idle low
// Notes:   Output bits are sampled late in the high phase because the
//          device answers three mclk after each falling edge
`timescale 1ns/1ps
module fdt_host_model
   import fdt_pkg::*;
#(
   parameter int HALF = 4
)(
   input  wire logic       mclk,
   output fdt_pins_s       pins,
   input  wire logic       dq1,
   input  wire logic       doe_n,
   output logic [7:0]      rx_byte,
   output logic            rx_oe_n,
   output logic            rx_stb
);
   initial begin
      pins    = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b1};
      rx_byte = 8'h00;
      rx_oe_n = 1'b0;
      rx_stb  = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk);
         // Clear only a raised strobe, never twice in one step
         if (rx_stb) begin
            rx_stb <= 1'b0;
         end
      end
   endtask

   // nbits data clocks, so a frame may be cut inside a byte
   task automatic frame(input logic [7:0] cmd, input logic [23:0] addr,
                        input int nbits, input logic rep);
      logic [39:0] sh;
      logic [7:0]  acc;
      logic        oe;
      sh  = {cmd, addr, 8'h00};
      acc = 8'h00;
      oe  = 1'b0;
      pins.cs_n <= 1'b0;
      tick(HALF);
      for (int i = 0; i < 40 + nbits; i++) begin
         pins.sclk <= 1'b0;
         // Dummy and data phases: released line toggles, never holds
         pins.din  <= (i < 32) ? sh[39-i] : ~pins.din;
         tick(HALF);
         pins.sclk <= 1'b1;
         tick(HALF);
         if (i >= 40) begin
            acc = {acc[6:0], dq1};
            oe  = oe | doe_n;
            if ((i - 40) % 8 == 7 && rep) begin
               rx_byte <= acc;
               rx_oe_n <= oe;
               rx_stb  <= 1'b1;
               oe = 1'b0;
            end
         end
      end
      pins.sclk <= 1'b0;
      tick(HALF);
      pins.cs_n <= 1'b1;
      pins.din  <= 1'b1;
      tick(HALF);
   endtask
endmodule

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the discovery-table read path
// Assumes: Host model drives the serial pins; bench drives straps
// Notes:   Expected bytes are queued by the driver, popped by a monitor
`timescale 1ns/1ps
module testbench
   import fdt_pkg::*;
;
   localparam logic [7:0] CMD = 8'h5A;
   logic       mclk;
   logic       rst;
   fdt_pins_s  pins;
   fdt_idcfg_s idcfg;
   logic       data_out_ff;
   logic       data_oe_n_ff;
   logic       busy_ff;
   logic [7:0] ext_id_ff;
   logic       dq1;
   logic [7:0] rx_byte;
   logic       rx_oe_n;
   logic       rx_stb;
   logic       quiet;
   logic [8:0] exp_q[$];
   int         n_errors;
   int         tests_run;

   // Released line shows the inverse so a missing enable never reads as data
   assign dq1 = (data_oe_n_ff === 1'b0) ? data_out_ff : ~data_out_ff;

   fdt_discovery_read #(.CMD_CODE(CMD)) u_dut (
      .mclk                 (mclk),
      .rst                  (rst),
      .sclk_pin             (pins.sclk),
      .cs_n_pin             (pins.cs_n),
      .serial_line_zero     (pins.din),
      .block_protect_scheme (idcfg.protect_alt),
      .execute_in_place     (idcfg.exec_basic),
      .shared_pin_reset     (idcfg.pin_reset),
      .data_out_ff          (data_out_ff),
      .data_oe_n_ff         (data_oe_n_ff),
      .busy_ff              (busy_ff),
      .ext_id_ff            (ext_id_ff)
   );

   fdt_host_model u_host (
      .mclk    (mclk),
      .pins    (pins),
      .dq1     (dq1),
      .doe_n   (data_oe_n_ff),
      .rx_byte (rx_byte),
      .rx_oe_n (rx_oe_n),
      .rx_stb  (rx_stb)
   );

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   function automatic logic [7:0] tbl(input logic [10:0] a);
      case (a)
         11'h000: tbl = 8'h53;
         11'h001: tbl = 8'h46;
         11'h002: tbl = 8'h44;
         11'h003: tbl = 8'h50;
         11'h004, 11'h006, 11'h008, 11'h009: tbl = 8'h00;
         11'h005, 11'h00A: tbl = 8'h01;
         11'h00B: tbl = 8'h09;
         11'h00C: tbl = 8'h30;
         11'h00D, 11'h00E: tbl = 8'h00;
         11'h030: tbl = 8'hE5;
         11'h031: tbl = 8'h20;
         11'h032: tbl = 8'hFB;
         11'h037: tbl = 8'h1F;
         11'h038: tbl = 8'h29;
         11'h039: tbl = 8'hEB;
         11'h03A, 11'h03C, 11'h03E: tbl = 8'h27;
         11'h03B: tbl = 8'h6B;
         11'h03D: tbl = 8'h3B;
         11'h03F: tbl = 8'hBB;
         default: tbl = 8'hFF;
      endcase
   endfunction

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h, expected %h",
                  $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Upper address bits are random: only 11 bits select the table
   task automatic rd(input logic [10:0] a, input int n);
      logic [23:0] full;
      full = {13'($urandom), a};
      for (int k = 0; k < n; k++) begin
         exp_q.push_back({1'b0, tbl(a + 11'(k))});
      end
      u_host.frame(CMD, full, 8 * n, 1'b1);
   endtask

   always @(posedge mclk) begin
      if (rx_stb === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h, expected none",
                     $time, {rx_oe_n, rx_byte});
         end else begin
            check({rx_oe_n, rx_byte}, exp_q.pop_front());
         end
      end
      if (quiet) begin
         check({8'h00, data_oe_n_ff}, 9'h001);
      end
   end

   initial begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      end_sim();
   end

   initial begin
      n_errors  = 0;
      tests_run = 0;
      rst   = 1'b1;
      quiet = 1'b0;
      idcfg = 3'b000;
      void'($urandom(32'h588cd20d));
      repeat (16) @(posedge mclk);
      check({8'h00, data_oe_n_ff}, 9'h001);
      check({8'h00, busy_ff}, 9'h000);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      for (int s = 0; s < 8; s++) begin
         idcfg <= 3'(s);
         repeat (3) @(posedge mclk);
         check({1'b0, ext_id_ff}, {3'b000, idcfg, 3'b000});
      end
      // Whole defined region in one burst, past every wrap length
      fork
         rd(11'h000, 64);
         begin
            repeat (100) @(posedge mclk);
            check({8'h00, busy_ff}, 9'h001);
         end
      join
      @(posedge mclk);
      check({8'h00, busy_ff}, 9'h000);
      rd(11'h7FC, 8);
      for (int f = 0; f < 6; f++) begin
         if ($urandom % 2 == 0) begin
            rd(11'($urandom % 64), 1 + $urandom % 4);
         end else begin
            rd(11'(11'h100 + $urandom % 1792), 1 + $urandom % 4);
         end
      end
      // Deselect in mid-byte: enable must have dropped five mclk later
      u_host.frame(CMD, 24'h00_0030, 13, 1'b0);
      @(posedge mclk);
      check({8'h00, data_oe_n_ff}, 9'h001);
      quiet <= 1'b1;
      u_host.frame(CMD ^ 8'(1 + $urandom % 255), 24'h00_0000, 16, 1'b0);
      quiet <= 1'b0;
      rd(11'h037, 3);
      repeat (4) @(posedge mclk);
      check(9'(exp_q.size()), 9'h000);
      end_sim();
   end
endmodule
